// ### src/chg_control_one.sv
// control word one: management bus word slave and decoded charger settings
// Summary of operation
// - bits 15:14 pick comparator assertion debounce
// - exit-option bit leaves learn on low battery
// - learn bit enables battery learn mode
// - learn mode only with battery present
// - bit 11 enables reverse power function
// - bit 10 enables audio filter
// - bits 9:7 override switching frequency
// - code 000 keeps pin-programmed frequency
// - bit 6 low enables turbo, gate on while turbo active
// - bit 5 disables monitors, battery only
// - bit 4 selects adapter or battery monitor
// - bit 3 enables system power monitor
// - bit 2 stops switching, forces gate on
// - bits 1:0 pick low voltage alert threshold
// - single cell uses fixed 2.4 V threshold
`timescale 1ns/100ps
`default_nettype none

module chg_control_one #(
    parameter logic [6:0] DEV_ADDR = chg_pkg::DEV_ADDR_DEFAULT,
    parameter int unsigned DEB_CYC_2 = chg_pkg::DEB_CYC_2,
    parameter int unsigned DEB_CYC_3 = chg_pkg::DEB_CYC_3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // management bus pins, open drain data
    input wire logic smb_clk_in,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe,
    // device status inputs
    input wire logic battery_absent_input,
    input wire logic battery_below_min_sys,
    input wire logic adapter_present,
    input wire logic single_cell,
    input wire logic turbo_active,
    input wire logic comparator_raw,
    input wire logic [9:0] programming_pin_khz,
    // register contents
    output logic [15:0] charger_control_one,
    // decoded settings
    output logic comparator_asserted,
    output logic learn_mode_active,
    output logic reverse_power_function_en,
    output logic audio_filter_en,
    output logic [9:0] switching_freq_khz,
    output logic turbo_en,
    output logic battery_path_gate,
    output logic current_monitor_en,
    output logic monitor_select_battery,
    output logic system_power_monitor_en,
    output logic system_output_switching_en,
    output logic [12:0] low_output_voltage_alert_mv
);

    chg_pkg::chg_state_e state;
    logic scl_q;
    logic sda_q;

    logic [3:0] bit_cnt;
    logic [2:0] byte_idx;

    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [7:0] lo_byte;

    logic cmd_ok;
    logic rd_mode;
    logic tx_hi;
    logic master_ack;

    logic learn_dropped;

    logic scl_rise;
    logic scl_fall;

    logic start_cond;
    logic stop_cond;

    logic byte_end;
    logic byte_ack;
    logic commit;

    assign scl_rise = smb_clk_in & ~scl_q;
    assign scl_fall = ~smb_clk_in & scl_q;
    assign start_cond = smb_clk_in & scl_q & sda_q & ~smb_data_in;
    assign stop_cond = smb_clk_in & scl_q & ~sda_q & smb_data_in;
    assign byte_end = (state == chg_pkg::ST_RX) && scl_fall && (bit_cnt == chg_pkg::BITS_PER_BYTE);

    // acknowledge decision for the byte just received
    always_comb begin
        unique case (byte_idx)
            chg_pkg::BYTE_ADDR: byte_ack = (rx_sh[7:1] == DEV_ADDR) && (!rx_sh[0] || cmd_ok);
            chg_pkg::BYTE_CMD: byte_ack = (rx_sh == chg_pkg::CMD_CHARGER_CONTROL_ONE);
            chg_pkg::BYTE_LO: byte_ack = 1'b1;
            chg_pkg::BYTE_HI: byte_ack = 1'b1;
            default: byte_ack = 1'b0;
        endcase
    end

    // store only once the high byte is in
    assign commit = byte_end && (byte_idx == chg_pkg::BYTE_HI) && cmd_ok && !rd_mode;

    // pin history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= smb_clk_in;
            sda_q <= smb_data_in;
        end
    end

    // byte engine of the word protocol
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= chg_pkg::ST_IDLE;
            bit_cnt <= '0;
            byte_idx <= chg_pkg::BYTE_ADDR;
            rx_sh <= '0;
            tx_sh <= '0;
            lo_byte <= '0;
            cmd_ok <= 1'b0;
            rd_mode <= 1'b0;
            tx_hi <= 1'b0;
            master_ack <= 1'b0;
        end else if (start_cond) begin
            // repeated start keeps the command
            state <= chg_pkg::ST_RX;
            bit_cnt <= '0;
            byte_idx <= chg_pkg::BYTE_ADDR;
            rd_mode <= 1'b0;
            tx_hi <= 1'b0;
        end else if (stop_cond) begin
            state <= chg_pkg::ST_IDLE;
            cmd_ok <= 1'b0;
            rd_mode <= 1'b0;
        end else begin
            unique case (state)
                chg_pkg::ST_IDLE: begin
                    bit_cnt <= '0;
                end

                chg_pkg::ST_RX: begin
                    if (scl_rise && bit_cnt != chg_pkg::BITS_PER_BYTE) begin
                        rx_sh <= {rx_sh[6:0], smb_data_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_end) begin
                        bit_cnt <= '0;
                        if (!byte_ack) begin
                            // refused byte, no acknowledge
                            state <= chg_pkg::ST_IDLE;
                        end else begin
                            state <= chg_pkg::ST_ACK;
                            byte_idx <= byte_idx + 3'h1;
                            if (byte_idx == chg_pkg::BYTE_ADDR && rx_sh[0]) begin
                                rd_mode <= 1'b1;
                                tx_sh <= charger_control_one[7:0];
                            end
                            if (byte_idx == chg_pkg::BYTE_CMD) begin
                                cmd_ok <= 1'b1;
                            end
                            if (byte_idx == chg_pkg::BYTE_LO) begin
                                lo_byte <= rx_sh;
                            end
                        end
                    end
                end

                chg_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state <= rd_mode ? chg_pkg::ST_TX : chg_pkg::ST_RX;
                        bit_cnt <= '0;
                    end
                end

                chg_pkg::ST_TX: begin
                    if (scl_fall) begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == chg_pkg::LAST_TX_BIT) begin
                            state <= chg_pkg::ST_MACK;
                            bit_cnt <= '0;
                        end
                    end
                end

                chg_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        master_ack <= ~smb_data_in;
                    end else if (scl_fall) begin
                        if (master_ack && !tx_hi) begin
                            state <= chg_pkg::ST_TX;
                            tx_sh <= charger_control_one[15:8];
                            tx_hi <= 1'b1;
                        end else begin
                            state <= chg_pkg::ST_IDLE;
                        end
                    end
                end

                default: begin
                    state <= chg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // data line is only ever pulled low
    assign smb_data_out = 1'b0;
    assign smb_data_oe = (state == chg_pkg::ST_ACK) || ((state == chg_pkg::ST_TX) && !tx_sh[7]);

    // the control word itself
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charger_control_one <= chg_pkg::CTRL_ONE_RESET;
        end else if (commit) begin
            charger_control_one <= {rx_sh, lo_byte};
        end
    end

    // learn mode, with latched exit on low battery
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            learn_dropped <= 1'b0;
            learn_mode_active <= 1'b0;
        end else begin
            if (!charger_control_one[chg_pkg::LEARN_EN_BIT]) begin
                learn_dropped <= 1'b0;
            end else if (learn_mode_active && charger_control_one[chg_pkg::LEARN_EXIT_BIT]
                         && battery_below_min_sys) begin
                learn_dropped <= 1'b1;
            end

            learn_mode_active <= charger_control_one[chg_pkg::LEARN_EN_BIT]
                                 && !battery_absent_input
                                 && !learn_dropped
                                 && !(charger_control_one[chg_pkg::LEARN_EXIT_BIT] && battery_below_min_sys);
        end
    end

    // decoded settings, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reverse_power_function_en <= 1'b0;
            audio_filter_en <= 1'b0;
            switching_freq_khz <= '0;
            turbo_en <= 1'b0;
            battery_path_gate <= 1'b0;
            current_monitor_en <= 1'b0;
            monitor_select_battery <= 1'b0;
            system_power_monitor_en <= 1'b0;
            system_output_switching_en <= 1'b0;
            low_output_voltage_alert_mv <= chg_pkg::ALERT_MV_0;
        end else begin
            reverse_power_function_en <= charger_control_one[chg_pkg::REVERSE_POWER_BIT];
            audio_filter_en <= charger_control_one[chg_pkg::AUDIO_FILTER_BIT];

            if (charger_control_one[chg_pkg::FREQ_HI:chg_pkg::FREQ_LO] == chg_pkg::FREQ_FROM_PIN) begin
                switching_freq_khz <= programming_pin_khz;
            end else begin
                switching_freq_khz <= chg_pkg::freq_khz(charger_control_one[chg_pkg::FREQ_HI:chg_pkg::FREQ_LO]);
            end

            turbo_en <= !charger_control_one[chg_pkg::TURBO_DIS_BIT];
            battery_path_gate <= (!charger_control_one[chg_pkg::TURBO_DIS_BIT] && turbo_active)
                                 || charger_control_one[chg_pkg::SWITCH_DIS_BIT];

            current_monitor_en <= adapter_present || !charger_control_one[chg_pkg::MON_DIS_BIT];
            monitor_select_battery <= charger_control_one[chg_pkg::MON_SEL_BIT];
            system_power_monitor_en <= charger_control_one[chg_pkg::SYS_POWER_BIT];
            system_output_switching_en <= !charger_control_one[chg_pkg::SWITCH_DIS_BIT];

            if (single_cell) begin
                low_output_voltage_alert_mv <= chg_pkg::ALERT_MV_ONE_CELL;
            end else begin
                unique case (charger_control_one[chg_pkg::ALERT_HI:chg_pkg::ALERT_LO])
                    2'h0: low_output_voltage_alert_mv <= chg_pkg::ALERT_MV_0;
                    2'h1: low_output_voltage_alert_mv <= chg_pkg::ALERT_MV_1;
                    2'h2: low_output_voltage_alert_mv <= chg_pkg::ALERT_MV_2;
                    2'h3: low_output_voltage_alert_mv <= chg_pkg::ALERT_MV_3;
                endcase
            end
        end
    end

    // comparator assertion debounce
    chg_debounce #(
        .CYC_0(chg_pkg::DEB_CYC_0),
        .CYC_1(chg_pkg::DEB_CYC_1),
        .CYC_2(DEB_CYC_2),
        .CYC_3(DEB_CYC_3)
    ) u_debounce (
        .clk(clk),
        .rst_n(rst_n),
        .raw_in(comparator_raw),
        .sel(charger_control_one[chg_pkg::DEB_SEL_HI:chg_pkg::DEB_SEL_LO]),
        .asserted(comparator_asserted)
    );

endmodule

`default_nettype wire

// ### src/chg_pkg.sv
// constants of the control word one block
package chg_pkg;

    // clock rate
    localparam int unsigned CLK_MHZ = 100;

    // bus command code of the control word
    localparam logic [7:0] CMD_CHARGER_CONTROL_ONE = 8'h3C;
    // device bus address (arbitrary value)
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

    // register reset value
    localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;

    // field positions
    localparam int DEB_SEL_HI = 15;
    localparam int DEB_SEL_LO = 14;
    localparam int LEARN_EXIT_BIT = 13;
    localparam int LEARN_EN_BIT = 12;
    localparam int REVERSE_POWER_BIT = 11;
    localparam int AUDIO_FILTER_BIT = 10;
    localparam int FREQ_HI = 9;
    localparam int FREQ_LO = 7;
    localparam int TURBO_DIS_BIT = 6;
    localparam int MON_DIS_BIT = 5;
    localparam int MON_SEL_BIT = 4;
    localparam int SYS_POWER_BIT = 3;
    localparam int SWITCH_DIS_BIT = 2;
    localparam int ALERT_HI = 1;
    localparam int ALERT_LO = 0;

    // comparator debounce times in us
    localparam int unsigned DEB_TIME_US_0 = 2;
    localparam int unsigned DEB_TIME_US_1 = 12;
    localparam int unsigned DEB_TIME_US_2 = 2000;
    localparam int unsigned DEB_TIME_US_3 = 5000000;
    localparam int unsigned DEB_CYC_0 = DEB_TIME_US_0 * CLK_MHZ;
    localparam int unsigned DEB_CYC_1 = DEB_TIME_US_1 * CLK_MHZ;
    localparam int unsigned DEB_CYC_2 = DEB_TIME_US_2 * CLK_MHZ;
    localparam int unsigned DEB_CYC_3 = DEB_TIME_US_3 * CLK_MHZ;
    localparam int DEB_CNT_W = 29;

    // code that keeps the pin frequency
    localparam logic [2:0] FREQ_FROM_PIN = 3'h0;

    // alert thresholds in mV
    localparam logic [12:0] ALERT_MV_0 = 13'd6000;
    localparam logic [12:0] ALERT_MV_1 = 13'd6300;
    localparam logic [12:0] ALERT_MV_2 = 13'd6600;
    localparam logic [12:0] ALERT_MV_3 = 13'd6900;
    localparam logic [12:0] ALERT_MV_ONE_CELL = 13'd2400;

    // bit counts of the byte engine
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // byte positions inside a word transaction
    localparam logic [2:0] BYTE_ADDR = 3'h0;
    localparam logic [2:0] BYTE_CMD = 3'h1;
    localparam logic [2:0] BYTE_LO = 3'h2;
    localparam logic [2:0] BYTE_HI = 3'h3;
    localparam logic [2:0] BYTE_EXTRA = 3'h4;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } chg_state_e;

    // override code to kHz
    function automatic logic [9:0] freq_khz(input logic [2:0] code);
        logic [9:0] f;
        f = 10'd913;
        case (code)
            3'h1: f = 10'd913;
            3'h2: f = 10'd839;
            3'h3: f = 10'd777;
            3'h4: f = 10'd723;
            3'h5: f = 10'd676;
            3'h6: f = 10'd635;
            3'h7: f = 10'd599;
            default: f = 10'd913;
        endcase
        return f;
    endfunction

endpackage

// ### src/chg_debounce.sv
// assertion debounce of the general purpose comparator output
`timescale 1ns/100ps
`default_nettype none

module chg_debounce #(
    parameter int unsigned CYC_0 = chg_pkg::DEB_CYC_0,
    parameter int unsigned CYC_1 = chg_pkg::DEB_CYC_1,
    parameter int unsigned CYC_2 = chg_pkg::DEB_CYC_2,
    parameter int unsigned CYC_3 = chg_pkg::DEB_CYC_3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // raw comparator and delay select
    input wire logic raw_in,
    input wire logic [1:0] sel,
    // debounced level
    output logic asserted
);

    logic [chg_pkg::DEB_CNT_W-1:0] cnt;
    logic [chg_pkg::DEB_CNT_W-1:0] limit;

    always_comb begin
        unique case (sel)
            2'h0: limit = chg_pkg::DEB_CNT_W'(CYC_0);
            2'h1: limit = chg_pkg::DEB_CNT_W'(CYC_1);
            2'h2: limit = chg_pkg::DEB_CNT_W'(CYC_2);
            2'h3: limit = chg_pkg::DEB_CNT_W'(CYC_3);
        endcase
    end

    // assertion waits the selected time, release is immediate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            asserted <= 1'b0;
        end else if (!raw_in) begin
            cnt <= '0;
            asserted <= 1'b0;
        end else if (cnt + 1'b1 >= limit) begin
            asserted <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

endmodule

`default_nettype wire

// ### testbench/chg_host_model.sv
// host model of the management bus with open-drain data
`timescale 1ns/100ps
`default_nettype none
module chg_host_model (
    // clock and pace
    input wire logic clk,
    input wire logic slow,
    // bus wires, data_low pulls the data line down
    output logic smb_clk,
    output logic data_low,
    input wire logic smb_data
);
    initial begin
        smb_clk = 1'b1;
        data_low = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data moves a cycle after clock falls: no false start or stop
    task automatic bit_io(input logic b, output logic s);
        wait_n(1);
        data_low = !b;
        wait_n(slow ? 12 : 4);
        smb_clk = 1'b1;
        wait_n(5);
        s = smb_data;
        smb_clk = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic get_byte(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(nack, s);
    endtask
    // serves as repeated start too, entered with the clock low
    task automatic start();
        wait_n(1);
        data_low = 1'b0;
        wait_n(4);
        smb_clk = 1'b1;
        wait_n(5);
        data_low = 1'b1;
        wait_n(5);
        smb_clk = 1'b0;
    endtask
    task automatic stop();
        wait_n(1);
        data_low = 1'b1;
        wait_n(4);
        smb_clk = 1'b1;
        wait_n(5);
        data_low = 1'b0;
        wait_n(5);
    endtask
    task automatic write_bytes(input logic [6:0] addr, input logic [7:0] cmd, input logic [23:0] data,
                               input int n, output logic [4:0] acks);
        logic a;
        acks = 5'h00;
        start();
        put_byte({addr, 1'b0}, acks[0]);
        put_byte(cmd, acks[1]);
        for (int i = 0; i < n; i++) begin
            put_byte(data[8*i +: 8], a);
            acks[2+i] = a;
        end
        stop();
    endtask
    task automatic read_word(input logic [6:0] addr, input logic [7:0] cmd, output logic [15:0] v,
                             output logic [2:0] acks);
        start();
        put_byte({addr, 1'b0}, acks[0]);
        put_byte(cmd, acks[1]);
        start();
        put_byte({addr, 1'b1}, acks[2]);
        get_byte(1'b0, v[7:0]);
        get_byte(1'b1, v[15:8]);
        stop();
    endtask
endmodule
`default_nettype wire

// ### testbench/chg_control_one_properties.sv
// timing checks on the decoded outputs of control word one
`timescale 1ns/100ps
`default_nettype none
module chg_control_one_properties #(
    parameter int unsigned DEB_CYC_2 = chg_pkg::DEB_CYC_2,
    parameter int unsigned DEB_CYC_3 = chg_pkg::DEB_CYC_3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // status inputs
    input wire logic battery_absent_input,
    input wire logic adapter_present,
    input wire logic single_cell,
    input wire logic turbo_active,
    input wire logic comparator_raw,
    input wire logic [9:0] programming_pin_khz,
    // register and decoded settings
    input wire logic [15:0] charger_control_one,
    input wire logic comparator_asserted,
    input wire logic learn_mode_active,
    input wire logic [9:0] switching_freq_khz,
    input wire logic turbo_en,
    input wire logic battery_path_gate,
    input wire logic current_monitor_en,
    input wire logic system_output_switching_en,
    input wire logic [12:0] low_output_voltage_alert_mv
);
    localparam logic [9:0] FREQ [8] = '{10'h000, 10'h391, 10'h347, 10'h309, 10'h2D3, 10'h2A4, 10'h27B, 10'h257};
    localparam logic [12:0] ALERT [4] = '{13'h1770, 13'h189C, 13'h19C8, 13'h1AF4};
    localparam int unsigned NEED [4] = '{chg_pkg::DEB_CYC_0, chg_pkg::DEB_CYC_1, DEB_CYC_2, DEB_CYC_3};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] high_cycles;
    logic [9:0] freq_exp;
    logic [12:0] alert_exp;
    assign freq_exp = charger_control_one[9:7] == 3'h0 ? programming_pin_khz : FREQ[charger_control_one[9:7]];
    assign alert_exp = single_cell ? 13'h0960 : ALERT[charger_control_one[1:0]];
    // length of the current high run of the raw comparator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_cycles <= 32'h0;
        end else if (comparator_raw) begin
            high_cycles <= high_cycles + 32'h1;
        end else begin
            high_cycles <= 32'h0;
        end
    end
    a_turbo_from_bit: assert property ($past(rst_n) |-> turbo_en == !$past(charger_control_one[6]))
        else $error("turbo enable does not match its bit");
    a_gate_drive: assert property ($past(rst_n) |-> battery_path_gate ==
        ((!$past(charger_control_one[6]) && $past(turbo_active)) || $past(charger_control_one[2])))
        else $error("battery path gate wrong");
    a_monitor_forced: assert property ($past(rst_n) |->
        current_monitor_en == ($past(adapter_present) || !$past(charger_control_one[5])))
        else $error("current monitor enable wrong");
    a_switching_stop: assert property ($past(rst_n) |-> system_output_switching_en == !$past(charger_control_one[2]))
        else $error("output switching enable wrong");
    a_freq_override: assert property ($past(rst_n) |-> switching_freq_khz == $past(freq_exp))
        else $error("switching frequency wrong");
    a_alert_level: assert property ($past(rst_n) |-> low_output_voltage_alert_mv == $past(alert_exp))
        else $error("alert threshold wrong");
    a_learn_needs_battery: assert property (learn_mode_active |->
        $past(charger_control_one[12]) && !$past(battery_absent_input))
        else $error("learn mode active without its bit or battery");
    a_debounce_wait: assert property ($rose(comparator_asserted) |->
        high_cycles + 1 >= NEED[charger_control_one[15:14]] && high_cycles <= NEED[charger_control_one[15:14]] + 2)
        else $error("comparator asserted after wrong debounce");
    a_debounce_drop: assert property (!$past(comparator_raw) |-> !comparator_asserted)
        else $error("comparator still asserted after raw low");
endmodule
`default_nettype wire

// ### testbench/chg_control_one_test.sv
// self-checking bench of control word one
`timescale 1ns/100ps
`default_nettype none
module chg_control_one_test;
    localparam int unsigned D2 = 20;
    localparam int unsigned D3 = 40;
    localparam logic [6:0] ADDR = chg_pkg::DEV_ADDR_DEFAULT;
    localparam logic [7:0] CMD = chg_pkg::CMD_CHARGER_CONTROL_ONE;
    localparam logic [9:0] FREQ [8] = '{10'h000, 10'h391, 10'h347, 10'h309, 10'h2D3, 10'h2A4, 10'h27B, 10'h257};
    localparam logic [12:0] ALERT [4] = '{13'h1770, 13'h189C, 13'h19C8, 13'h1AF4};
    localparam int unsigned NEED [4] = '{32'hC8, 32'h4B0, D2, D3};
    logic clk = 1'b0;
    logic rst_n, smb_clk, host_low, slow, smb_data, smb_data_out, smb_data_oe;
    logic battery_absent_input, battery_below_min_sys, adapter_present, single_cell, turbo_active, comparator_raw;
    logic [9:0] programming_pin_khz, switching_freq_khz;
    logic [15:0] charger_control_one, d;
    logic comparator_asserted, learn_mode_active, reverse_power_function_en, audio_filter_en, turbo_en;
    logic battery_path_gate, current_monitor_en, monitor_select_battery, system_power_monitor_en;
    logic system_output_switching_en;
    logic [12:0] low_output_voltage_alert_mv;
    logic [4:0] acks;
    int bad_count = 0;
    int comparisons = 0;
    int n;
    // open-drain data line with pull-up
    assign smb_data = !(host_low || (smb_data_oe && !smb_data_out));
    always #5 clk = ~clk;
    chg_host_model i_host (.clk, .slow, .smb_clk, .data_low(host_low), .smb_data);
    chg_control_one #(.DEB_CYC_2(D2), .DEB_CYC_3(D3)) i_dut (.smb_clk_in(smb_clk), .smb_data_in(smb_data), .*);
    task automatic report_and_stop();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] v);
        i_host.write_bytes(ADDR, CMD, {8'h00, v}, 2, acks);
        check("write acks", 16'h000F, 16'(acks));
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic [15:0] exp);
        logic [15:0] v;
        logic [2:0] a;
        i_host.read_word(ADDR, CMD, v, a);
        check("read acks", 16'h0007, 16'(a));
        check("read data", exp, v);
    endtask
    task automatic check_outs(input logic [15:0] v);
        check("register", v, charger_control_one);
        check("reverse power", 16'(v[11]), 16'(reverse_power_function_en));
        check("audio filter", 16'(v[10]), 16'(audio_filter_en));
        check("frequency", 16'(v[9:7] == 3'h0 ? programming_pin_khz : FREQ[v[9:7]]),
              16'(switching_freq_khz));
        check("turbo", 16'(!v[6]), 16'(turbo_en));
        check("gate", 16'((!v[6] && turbo_active) || v[2]), 16'(battery_path_gate));
        check("monitor", 16'(adapter_present || !v[5]), 16'(current_monitor_en));
        check("monitor select", 16'(v[4]), 16'(monitor_select_battery));
        check("power monitor", 16'(v[3]), 16'(system_power_monitor_en));
        check("switching", 16'(!v[2]), 16'(system_output_switching_en));
        check("alert", 16'(single_cell ? 13'h0960 : ALERT[v[1:0]]), 16'(low_output_voltage_alert_mv));
    endtask
    initial begin
        rst_n = 1'b0;
        slow = 1'b0;
        {battery_absent_input, battery_below_min_sys, adapter_present, single_cell, turbo_active} = 5'h00;
        comparator_raw = 1'b0;
        programming_pin_khz = 10'h1F4;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check_outs(16'h0000);
        rd(16'h0000);
        // every frequency, alert and debounce code, learn bits 13:12 held at 0, inputs varied
        for (int k = 0; k < 8; k++) begin
            d = {k[1:0], 2'h0, k[0], k[1], k[2:0], k[0], k[1], k[2], k[0], k[1], k[1:0]};
            turbo_active = k[2];
            adapter_present = k[1] & k[2];
            single_cell = (k == 7);
            slow = k[0];
            wr(d);
            rd(d);
            check_outs(d);
        end
        wr(16'h0000);
        check_outs(16'h0000);
        wr(16'h1000);
        check("learn on", 16'h0001, 16'(learn_mode_active));
        battery_absent_input = 1'b1;
        repeat (2) @(negedge clk);
        check("learn no battery", 16'h0000, 16'(learn_mode_active));
        battery_absent_input = 1'b0;
        battery_below_min_sys = 1'b1;
        repeat (2) @(negedge clk);
        check("learn kept", 16'h0001, 16'(learn_mode_active));
        wr(16'h3000);
        check("learn exit", 16'h0000, 16'(learn_mode_active));
        battery_below_min_sys = 1'b0;
        wr(16'h0000);
        check("learn off", 16'h0000, 16'(learn_mode_active));
        i_host.write_bytes(ADDR, CMD, 24'h0000A5, 1, acks);
        check("low byte only", 16'h0000, charger_control_one);
        i_host.write_bytes(ADDR, 8'h3D, 24'h00FFFF, 2, acks);
        check("other command acks", 16'h0001, 16'(acks));
        check("other command", 16'h0000, charger_control_one);
        i_host.write_bytes(ADDR ^ 7'h01, CMD, 24'h00FFFF, 2, acks);
        check("other address acks", 16'h0000, 16'(acks));
        i_host.write_bytes(ADDR, CMD, 24'h5A1234, 3, acks);
        check("extra byte acks", 16'h000F, 16'(acks));
        rd(16'h1234);
        for (int s = 0; s < 4; s++) begin
            wr({s[1:0], 14'h0000});
            comparator_raw = 1'b1;
            n = 0;
            while (comparator_asserted !== 1'b1 && n < NEED[s] + 5) begin
                @(negedge clk);
                n++;
            end
            comparisons++;
            if (n + 1 < NEED[s] || n > NEED[s] + 1) begin
                bad_count++;
                $display("[FAIL] debounce expected %0d seen %0d", NEED[s], n);
                if (n >= NEED[s] + 5) report_and_stop();
            end
            comparator_raw = 1'b0;
            repeat (2) @(negedge clk);
            check("debounce release", 16'h0000, 16'(comparator_asserted));
        end
        report_and_stop();
    end
endmodule
bind chg_control_one chg_control_one_properties #(.DEB_CYC_2(DEB_CYC_2), .DEB_CYC_3(DEB_CYC_3)) i_props (.*);
`default_nettype wire
